// *** rtl/uocs_pkg.sv ***
package uocs_pkg;

  // register map, one aligned word
  localparam logic [3:0] OCS_ADDR = 4'h0;

  // field positions within the control and status byte
  localparam int BIT_SIDE  = 7;
  localparam int BIT_FSHS  = 6;
  localparam int BIT_LS    = 5;
  localparam int BIT_VBHI  = 4;
  localparam int BIT_VBLO  = 3;
  localparam int BIT_HOST  = 2;
  localparam int BIT_RSVD  = 1;
  localparam int BIT_SESS  = 0;

  localparam logic [7:0] OCS_RESET = 8'h00;

  // vbus level codes
  localparam logic [1:0] VB_BELOW_END  = 2'h0;
  localparam logic [1:0] VB_END_AVALID = 2'h1;
  localparam logic [1:0] VB_AVALID_VBV = 2'h2;
  localparam logic [1:0] VB_ABOVE_VBV  = 2'h3;

  // attached peripheral speed class, one-hot
  typedef enum logic [2:0] {
    SPD_NONE = 3'b001,
    SPD_FSHS = 3'b010,
    SPD_LS   = 3'b100
  } uocs_speed_t;

  // status from the port side
  typedef struct packed {
    logic sessEnd;
    logic aValid;
    logic vbusValid;
    logic bSide;
    logic hostRole;
    logic suspended;
    logic connFs;
    logic connLs;
    logic chirpSeen;
    logic sessActive;
  } uocs_port_t;

  // avalon request bundle
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } uocs_req_t;

endpackage

// *** rtl/uocs_top.sv ***
// Local design decisions: the address map and the Avalon-MM interface to the registers.
module uocs_top
  import uocs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire uocs_pkg::uocs_req_t avReq,
  output logic [31:0]            avReaddata,
  output logic                   avWaitrequest,
  input  wire uocs_pkg::uocs_port_t portIn,
  output logic                   sessionReq,
  output logic                   softDisconnect,
  output logic                   highSpeedPeer
);
  import uocs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rstMeta_q;
  logic rstSync_q;
  logic rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  ////////////////////////////////////////////////////////////////////////////
  // port status synchroniser
  uocs_port_t portMeta_q;
  uocs_port_t port_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      portMeta_q <= '0;
      port_q     <= '0;
    end else begin
      portMeta_q <= portIn;
      port_q     <= portMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vbus band encoding
  function automatic logic [1:0] vbusBand(input uocs_port_t p);
    if (p.vbusValid) begin
      vbusBand = VB_ABOVE_VBV;
    end else if (p.aValid) begin
      vbusBand = VB_AVALID_VBV;
    end else if (!p.sessEnd) begin
      vbusBand = VB_END_AVALID;
    end else begin
      vbusBand = VB_BELOW_END;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic busWr;
  logic busRd;
  logic hitOcs;
  logic waitDone_q;

  assign hitOcs = (avReq.address == OCS_ADDR);
  assign busWr  = avReq.write && waitDone_q;
  assign busRd  = avReq.read && waitDone_q;

  // one wait state per access
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      waitDone_q <= 1'b0;
    end else begin
      waitDone_q <= (avReq.read || avReq.write) && !waitDone_q;
    end
  end
  assign avWaitrequest = (avReq.read || avReq.write) && !waitDone_q;

  logic swWrSess;
  assign swWrSess = busWr && hitOcs && avReq.byteenable[0];

  ////////////////////////////////////////////////////////////////////////////
  // speed class tracking
  uocs_speed_t speed_q;
  logic        hs_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      speed_q <= SPD_NONE;
    end else begin
      case (speed_q)
        SPD_NONE: begin
          if (port_q.hostRole && port_q.connFs) begin
            speed_q <= SPD_FSHS;
          end else if (port_q.hostRole && port_q.connLs) begin
            speed_q <= SPD_LS;
          end
        end
        SPD_FSHS: begin
          if (!port_q.hostRole || !port_q.connFs) begin
            speed_q <= SPD_NONE;
          end
        end
        SPD_LS: begin
          if (!port_q.hostRole || !port_q.connLs) begin
            speed_q <= SPD_NONE;
          end
        end
        default: speed_q <= SPD_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      hs_q <= 1'b0;
    end else if (speed_q != SPD_FSHS) begin
      hs_q <= 1'b0;
    end else if (port_q.chirpSeen) begin
      hs_q <= 1'b1;
    end
  end
  assign highSpeedPeer = hs_q;

  ////////////////////////////////////////////////////////////////////////////
  // session bit
  logic sess_q;
  logic sessActPrev_q;
  logic sessRise;
  logic sessFall;

  assign sessRise = port_q.sessActive && !sessActPrev_q;
  assign sessFall = !port_q.sessActive && sessActPrev_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sessActPrev_q <= 1'b0;
    end else begin
      sessActPrev_q <= port_q.sessActive;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sess_q <= 1'b0;
    end else if (port_q.bSide && sessRise) begin
      sess_q <= 1'b1;
    end else if (port_q.bSide && sessFall && !swWrSess) begin
      sess_q <= 1'b0;
    end else if (swWrSess) begin
      sess_q <= avReq.writedata[BIT_SESS];
    end
  end
  assign sessionReq = sess_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      softDisconnect <= 1'b0;
    end else if (swWrSess && sess_q && !avReq.writedata[BIT_SESS] && port_q.suspended) begin
      softDisconnect <= 1'b1;
    end else if (swWrSess && avReq.writedata[BIT_SESS]) begin
      softDisconnect <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status byte assembly
  logic [7:0] status;

  always_comb begin
    status           = OCS_RESET;
    status[BIT_SIDE] = port_q.bSide;
    status[BIT_FSHS] = port_q.hostRole && (speed_q == SPD_FSHS);
    status[BIT_LS]   = port_q.hostRole && (speed_q == SPD_LS);
    {status[BIT_VBHI], status[BIT_VBLO]} = vbusBand(port_q);
    status[BIT_HOST] = port_q.hostRole;
    status[BIT_RSVD] = 1'b0;
    status[BIT_SESS] = sess_q;
  end

  // read data register
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      avReaddata <= '0;
    end else if (avReq.read && !waitDone_q) begin
      avReaddata <= hitOcs ? {24'h000000, status} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // host bit follows role
  property p_host_bit;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs |-> avReaddata[BIT_HOST] == $past(port_q.hostRole);
  endproperty
  a_host_bit: assert property (p_host_bit) else $error("host bit wrong");

  property p_rsvd_zero;
    @(posedge clk) disable iff (!rstN)
      busRd |-> avReaddata[BIT_RSVD] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit nonzero");

  property p_fs_host;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs && !$past(port_q.hostRole) |-> !avReaddata[BIT_FSHS] && !avReaddata[BIT_LS];
  endproperty
  a_fs_host: assert property (p_fs_host) else $error("speed bit outside host");

  property p_ls_set;
    @(posedge clk) disable iff (!rstN)
      port_q.hostRole && port_q.connLs && !port_q.connFs && speed_q == SPD_NONE
        ##1 port_q.hostRole && port_q.connLs |-> speed_q == SPD_LS;
  endproperty
  a_ls_set: assert property (p_ls_set) else $error("low speed not caught");

  property p_hs_chirp;
    @(posedge clk) disable iff (!rstN)
      speed_q == SPD_FSHS && port_q.chirpSeen |=> hs_q;
  endproperty
  a_hs_chirp: assert property (p_hs_chirp) else $error("chirp missed");

  property p_vbus;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs && $past(port_q.vbusValid) |-> avReaddata[BIT_VBHI:BIT_VBLO] == VB_ABOVE_VBV;
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus code wrong");

  property p_b_sess;
    @(posedge clk) disable iff (!rstN)
      port_q.bSide && sessRise |=> sess_q;
  endproperty
  a_b_sess: assert property (p_b_sess) else $error("b side session not set");

  property p_a_write;
    @(posedge clk) disable iff (!rstN)
      swWrSess && !sessRise |=> sess_q == $past(avReq.writedata[BIT_SESS]) || $past(sessFall);
  endproperty
  a_a_write: assert property (p_a_write) else $error("session write lost");

  property p_disc;
    @(posedge clk) disable iff (!rstN)
      swWrSess && sess_q && !avReq.writedata[BIT_SESS] && port_q.suspended |=> softDisconnect;
  endproperty
  a_disc: assert property (p_disc) else $error("no soft disconnect");

  property p_side;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs |-> avReaddata[BIT_SIDE] == $past(port_q.bSide);
  endproperty
  a_side: assert property (p_side) else $error("side bit wrong");

  property p_b_clear;
    @(posedge clk) disable iff (!rstN)
      port_q.bSide && sessFall && !swWrSess |=> !sess_q;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("b side session not cleared");

  property p_ls_bit;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs && $past(port_q.hostRole) && $past(speed_q) == SPD_LS
        |-> avReaddata[BIT_LS] && !avReaddata[BIT_FSHS];
  endproperty
  a_ls_bit: assert property (p_ls_bit) else $error("low speed bit wrong");

  property p_vbus_low;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs && $past(port_q.sessEnd) && !$past(port_q.aValid)
        && !$past(port_q.vbusValid) |-> avReaddata[BIT_VBHI:BIT_VBLO] == VB_BELOW_END;
  endproperty
  a_vbus_low: assert property (p_vbus_low) else $error("low vbus code wrong");

  property p_hs_clear;
    @(posedge clk) disable iff (!rstN)
      speed_q != SPD_FSHS |=> !hs_q;
  endproperty
  a_hs_clear: assert property (p_hs_clear) else $error("high speed flag stuck");

  property p_sess_read;
    @(posedge clk) disable iff (!rstN)
      busRd && hitOcs |-> avReaddata[BIT_SESS] == $past(sess_q);
  endproperty
  a_sess_read: assert property (p_sess_read) else $error("session bit read wrong");

  c_write: cover property (@(posedge clk) disable iff (!rstN) swWrSess);
  c_hs: cover property (@(posedge clk) disable iff (!rstN) $rose(hs_q));
  c_disc: cover property (@(posedge clk) disable iff (!rstN) $rose(softDisconnect));
  c_ls: cover property (@(posedge clk) disable iff (!rstN) speed_q == SPD_LS);
  c_b_sess: cover property (@(posedge clk) disable iff (!rstN) port_q.bSide && sessRise);

endmodule

// *** bench/uocs_port_model.sv ***
// port side model: turns the bench's wanted line state into the port levels
module uocs_port_model
  import uocs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [1:0] band,
  input  wire logic [4:0] ctl,
  input  wire logic [1:0] spd,
  output uocs_pkg::uocs_port_t portOut
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // sessEnd drops, then aValid and vbusValid rise one after another as vbus climbs
  // role, side and line state; chirps only come from a full speed peer
  // vbus, side, chirp, session
  always @(posedge clk) begin
    portOut.sessEnd    <= (band == 2'h0);
    portOut.aValid     <= (band >= 2'h2);
    portOut.vbusValid  <= (band == 2'h3);
    portOut.bSide      <= ctl[4];
    portOut.hostRole   <= ctl[3];
    portOut.suspended  <= ctl[2];
    portOut.sessActive <= ctl[1];
    portOut.chirpSeen  <= ctl[0] & spd[1];
    portOut.connFs     <= spd[1];
    portOut.connLs     <= spd[0];
  end
endmodule

// *** bench/test_usb_otg_device_control_status.sv ***
module test_usb_otg_device_control_status
  import uocs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        resetN = 1'b0;
  uocs_req_t   req = '0;
  logic [31:0] rdata;
  logic        waitReq, sessReq, softDisc, hsPeer;
  uocs_port_t  portIn;
  logic [1:0]  band = 2'h0;
  logic [4:0]  ctl = 5'h00; // side, host, suspend, session, chirp
  logic [1:0]  spd = 2'h0;  // full/high, low
  logic        sess = 1'b0;
  logic [31:0] expQ[$];
  int          errorCnt = 0;
  int          checks = 0;

  always #4 clk = ~clk;

  uocs_top DUT (.clk(clk), .reset_n(resetN), .avReq(req), .avReaddata(rdata),
    .avWaitrequest(waitReq), .portIn(portIn), .sessionReq(sessReq),
    .softDisconnect(softDisc), .highSpeedPeer(hsPeer));
  uocs_port_model peer (.clk(clk), .band(band), .ctl(ctl), .spd(spd), .portOut(portIn));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp32(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmpBit(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask

  // one avalon cycle: hold until waitrequest is seen low at a rising edge
  task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d);
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hF;
    req.read <= ~wr;
    req.write <= wr;
    // only the watchdog ends a wait that never sees waitrequest low
    do begin
      @(posedge clk);
    end while (waitReq !== 1'b0);
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask

  // expected status word from the line state the bench asked for
  task automatic rdExp(input logic [3:0] a);
    logic h;
    h = ctl[3];
    expQ.push_back(a != OCS_ADDR ? 32'h0 :
      {24'h0, ctl[4], h & spd[1], h & spd[0], band, h, 1'b0, sess});
    busOp(1'b0, a, 32'h0);
  endtask

  task automatic wrSess(input logic v);
    sess = v;
    busOp(1'b1, OCS_ADDR, {$urandom} & 32'hFFFF_FFFE | v);
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // read data monitor, taken at the edge where waitrequest is seen low
  always @(posedge clk) begin
    if (req.read === 1'b1 && waitReq === 1'b0 && expQ.size() > 0)
      cmp32("status", expQ.pop_front(), rdata);
  end

  task automatic closeOut();
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    closeOut();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h238eb7b9));
    repeat (8) @(posedge clk);
    resetN <= 1'b1;
    repeat (4) @(posedge clk);
    rdExp(OCS_ADDR);
    rdExp(4'h5);
    // random bands, sides and roles
    for (int i = 0; i < 12; i++) begin
      band <= 2'($urandom);
      ctl <= {3'($urandom) & 3'h6, 2'h0};
      settle();
      rdExp(OCS_ADDR);
    end
    // host speed detection and chirp
    ctl <= 5'h08;
    spd <= 2'h2;
    settle();
    rdExp(OCS_ADDR);
    cmpBit("hs peer", 1'b0, hsPeer);
    ctl <= 5'h09;
    settle();
    cmpBit("hs peer", 1'b1, hsPeer);
    spd <= 2'h0;
    settle();
    spd <= 2'h1;
    settle();
    rdExp(OCS_ADDR);
    spd <= 2'h0;
    ctl <= 5'h00;
    settle();
    // a side session start and end by software
    wrSess(1'b1);
    cmpBit("session", 1'b1, sessReq);
    rdExp(OCS_ADDR);
    busOp(1'b1, 4'h3, 32'h0);
    cmpBit("session", 1'b1, sessReq);
    wrSess(1'b0);
    cmpBit("session", 1'b0, sessReq);
    // disconnect while suspended
    wrSess(1'b1);
    ctl <= 5'h04;
    settle();
    wrSess(1'b0);
    cmpBit("soft disconnect", 1'b1, softDisc);
    wrSess(1'b1);
    cmpBit("soft disconnect", 1'b0, softDisc);
    ctl <= 5'h00;
    settle();
    wrSess(1'b0);
    cmpBit("soft disconnect", 1'b0, softDisc);
    // b side session follows the peer
    ctl <= 5'h12;
    settle();
    sess = 1'b1;
    cmpBit("session", 1'b1, sessReq);
    rdExp(OCS_ADDR);
    ctl <= 5'h10;
    settle();
    sess = 1'b0;
    cmpBit("session", 1'b0, sessReq);
    rdExp(OCS_ADDR);
    repeat (4) @(posedge clk);
    cmpBit("queue empty", 1'b1, expQ.size() == 0);
    closeOut();
  end
endmodule
